// >>> hw/ladcl_params.svh
// ladcl_params.svh: offsets, field positions, reset values and codes of the
// load-adaptive current learning block. assumes inclusion by bare name.
`ifndef LADCL_PARAMS_SVH
`define LADCL_PARAMS_SVH

// ****************************************
// register offsets (plain port, byte address)
// ****************************************
`define LADCL_OFS_CTRL      8'h00
`define LADCL_OFS_LEARN     8'h04
`define LADCL_OFS_STATUS    8'h08
`define LADCL_OFS_LOSS_LO   8'h0C
`define LADCL_OFS_LOSS_HI   8'h10
`define LADCL_OFS_BAND      8'h14
`define LADCL_OFS_LIMIT     8'h18
`define LADCL_OFS_PRESENT   8'h1C

// ****************************************
// field positions
// ****************************************
`define LADCL_CTRL_EN_BIT     0
`define LADCL_CTRL_COMP_BIT   1
`define LADCL_CTRL_GO_BIT     2
`define LADCL_ST_DONE_BIT     0
`define LADCL_ST_ABOVE_BIT    1
`define LADCL_ST_BELOW_BIT    2
`define LADCL_LRN_BASE_LSB    0
`define LADCL_LRN_INC_LSB     8
`define LADCL_LRN_DWELL_LSB   16
`define LADCL_BAND_LO_LSB     0
`define LADCL_BAND_HI_LSB     8
`define LADCL_LIM_FLOOR_LSB   0
`define LADCL_LIM_CEIL_LSB    8

// ****************************************
// reset values and codes
// ****************************************
`define LADCL_RST_BYTE      8'h00
`define LADCL_RST_CEIL      8'hFF
`define LADCL_RST_LOSS      11'h000
`define LADCL_RST_BASE      5'h00
`define LADCL_RST_CODE      2'h0
`define LADCL_INC_C0        8'h80
`define LADCL_INC_C1        8'h10
`define LADCL_INC_C2        8'h20
`define LADCL_INC_C3        8'h40
`define LADCL_DWELL_C0      6'h08
`define LADCL_DWELL_C1      6'h10
`define LADCL_DWELL_C2      6'h18
`define LADCL_DWELL_C3      6'h20
`define LADCL_BASE_SHIFT    3
`define LADCL_ONE_BYTE      8'h01
`define LADCL_ONE_DWELL     6'h01
`define LADCL_ZERO_DWELL    6'h00
// supply scaling: 256 means unity gain (q8 fraction)
`define LADCL_UNITY_GAIN    9'h100
`define LADCL_GAIN_SHIFT    8

`endif

// >>> hw/ladcl_pkg.sv
// ladcl_pkg.sv: types of the load-adaptive current learning block.
// assumes ladcl_params.svh is compiled alongside.
package ladcl_pkg;

  // learning sequencer states, gray coded along idle->low->high; high->idle flips both bits
  typedef enum logic [1:0] {
    LADCL_IDLE = 2'h0,
    LADCL_LOW  = 2'h1,
    LADCL_HIGH = 2'h3
  } ladcl_state_t;

  // register-bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ladcl_bus_req_t;

  // measurement inputs from the metric engine
  typedef struct packed {
    logic [10:0] loss;
    logic [7:0]  load;
    logic        valid;
    logic        half_cycle;
  } ladcl_meas_t;

endpackage

// >>> hw/ladcl_top.sv
// ladcl_top.sv: learning sequencer, hysteretic current loop and registers of
// the load-adaptive coil current block.
// assumes metric inputs and the half-cycle strobe are on clk; supply gain arrives
// as a q8 value on clk too.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "ladcl_params.svh"

module ladcl_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // register port
  input  wire ladcl_pkg::ladcl_bus_req_t bus_req,
  output logic [31:0]                bus_rdata,
  // metric engine
  input  wire ladcl_pkg::ladcl_meas_t meas,
  input  wire logic [8:0]            supply_gain,
  // coil current regulator
  output logic [7:0]                 coil_current,
  output logic                       adapt_active
);

  // ****************************************
  // registers
  // ****************************************
  logic                      enable_r;
  logic                      comp_r;
  logic                      go_r;
  logic                      done_r;
  logic                      above_r;
  logic                      below_r;
  logic [4:0]                base_r;
  logic [1:0]                inc_sel_r;
  logic [1:0]                dwell_sel_r;
  logic [10:0]               loss_lo_r;
  logic [10:0]               loss_hi_r;
  logic [7:0]                band_hi_r;
  logic [7:0]                band_lo_r;
  logic [7:0]                floor_r;
  logic [7:0]                ceil_r;
  logic [7:0]                current_r;
  logic [7:0]                current_nxt;
  logic [5:0]                dwell_cnt_r;
  logic                      finish;
  ladcl_pkg::ladcl_state_t   state_r;
  ladcl_pkg::ladcl_state_t   state_nxt;
  logic [31:0]               rdata_nxt;

  logic wr_ctrl;
  logic wr_learn;
  logic wr_band;
  logic wr_limit;
  logic wr_lo;
  logic wr_hi;
  assign wr_ctrl  = bus_req.wr && (bus_req.addr == `LADCL_OFS_CTRL);
  assign wr_learn = bus_req.wr && (bus_req.addr == `LADCL_OFS_LEARN);
  assign wr_band  = bus_req.wr && (bus_req.addr == `LADCL_OFS_BAND);
  assign wr_limit = bus_req.wr && (bus_req.addr == `LADCL_OFS_LIMIT);
  assign wr_lo    = bus_req.wr && (bus_req.addr == `LADCL_OFS_LOSS_LO);
  assign wr_hi    = bus_req.wr && (bus_req.addr == `LADCL_OFS_LOSS_HI);

  // ****************************************
  // level and dwell decode
  // ****************************************
  logic [7:0] inc_val;
  logic [5:0] dwell_val;
  logic [7:0] level_lo;
  logic [7:0] level_hi;

  always_comb begin
    unique case (inc_sel_r)
      2'h0:    inc_val = `LADCL_INC_C0;
      2'h1:    inc_val = `LADCL_INC_C1;
      2'h2:    inc_val = `LADCL_INC_C2;
      2'h3:    inc_val = `LADCL_INC_C3;
    endcase
    unique case (dwell_sel_r)
      2'h0:    dwell_val = `LADCL_DWELL_C0;
      2'h1:    dwell_val = `LADCL_DWELL_C1;
      2'h2:    dwell_val = `LADCL_DWELL_C2;
      2'h3:    dwell_val = `LADCL_DWELL_C3;
    endcase
  end

  // wraps mod 256 if software breaks the 255 limit on the second level;
  // no saturation here, because a clipped level would teach a wrong loss slope
  assign level_lo = 8'({3'h0, base_r} << `LADCL_BASE_SHIFT);
  assign level_hi = 8'(level_lo + inc_val);

  // ****************************************
  // supply scaling
  // ****************************************
  logic [7:0]  band_hi_eff;
  logic [7:0]  band_lo_eff;
  logic [10:0] loss_eff;
  logic [8:0]  gain;

  function automatic logic [10:0] scale11(input logic [10:0] v, input logic [8:0] g);
    logic [19:0] p;
    p = 20'(v) * 20'(g);
    scale11 = (p[19:`LADCL_GAIN_SHIFT] > 12'h7FF) ? 11'h7FF : p[`LADCL_GAIN_SHIFT +: 11];
  endfunction

  assign gain        = comp_r ? supply_gain : `LADCL_UNITY_GAIN;
  assign band_hi_eff = 8'(scale11({3'h0, band_hi_r}, gain) > 11'h0FF ? 11'h0FF
                                                                  : scale11({3'h0, band_hi_r}, gain));
  assign band_lo_eff = 8'(scale11({3'h0, band_lo_r}, gain) > 11'h0FF ? 11'h0FF
                                                                  : scale11({3'h0, band_lo_r}, gain));
  assign loss_eff    = scale11(meas.loss, gain);

  // ****************************************
  // learning sequencer
  // ****************************************
  // the coil follows the state one edge later, so the first half-cycle of a
  // level is already counted while the regulator still settles
  logic dwell_end;
  assign dwell_end = meas.half_cycle && (dwell_cnt_r == 6'(dwell_val - `LADCL_ONE_DWELL));
  assign finish    = (state_r == ladcl_pkg::LADCL_HIGH) && dwell_end;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ladcl_pkg::LADCL_IDLE: if (go_r && enable_r) state_nxt = ladcl_pkg::LADCL_LOW;
      ladcl_pkg::LADCL_LOW:  if (dwell_end) state_nxt = ladcl_pkg::LADCL_HIGH;
      ladcl_pkg::LADCL_HIGH: if (dwell_end) state_nxt = ladcl_pkg::LADCL_IDLE;
      default:               state_nxt = ladcl_pkg::LADCL_IDLE;
    endcase
    if (!enable_r) state_nxt = ladcl_pkg::LADCL_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) state_r <= ladcl_pkg::LADCL_IDLE;
    else          state_r <= state_nxt;
  end

  // dwell counter restarts on every level change
  always_ff @(posedge clk) begin
    if (!reset_n || state_nxt != state_r) dwell_cnt_r <= `LADCL_ZERO_DWELL;
    else if (meas.half_cycle && state_r != ladcl_pkg::LADCL_IDLE)
      dwell_cnt_r <= 6'(dwell_cnt_r + `LADCL_ONE_DWELL);
  end

  // loss sample at the last half-cycle of each level is kept, valid or not
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      loss_lo_r <= `LADCL_RST_LOSS;
      loss_hi_r <= `LADCL_RST_LOSS;
    end else begin
      if (state_r == ladcl_pkg::LADCL_LOW && dwell_end)
        loss_lo_r <= loss_eff;
      else if (wr_lo)
        loss_lo_r <= bus_req.wdata[10:0];
      if (finish)
        loss_hi_r <= loss_eff;
      else if (wr_hi)
        loss_hi_r <= bus_req.wdata[10:0];
    end
  end

  // go self-clears on finish; a write in the finish cycle loses to the clear
  always_ff @(posedge clk) begin
    if (!reset_n)     go_r <= 1'b0;
    else if (finish || !enable_r) go_r <= 1'b0;
    else if (wr_ctrl && bus_req.wdata[`LADCL_CTRL_GO_BIT]) go_r <= 1'b1;
  end

  // done is set at finish, cleared by a new launch; set wins
  always_ff @(posedge clk) begin
    if (!reset_n)   done_r <= 1'b0;
    else if (finish) done_r <= 1'b1;
    else if (wr_ctrl && bus_req.wdata[`LADCL_CTRL_GO_BIT]) done_r <= 1'b0;
  end

  // ****************************************
  // hysteretic current loop
  // ****************************************
  logic over;
  logic under;
  // one count per half-cycle keeps the loop slow enough not to chase noise;
  // a large load step therefore takes many half-cycles to settle
  assign over  = meas.load > band_hi_eff;
  assign under = meas.load < band_lo_eff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      above_r <= 1'b0;
      below_r <= 1'b0;
    end else if (meas.valid && enable_r) begin
      above_r <= over;
      below_r <= under;
    end
  end

  always_comb begin
    current_nxt = current_r;
    if (!enable_r) begin
      current_nxt = ceil_r;
    end else if (state_r == ladcl_pkg::LADCL_LOW) begin
      current_nxt = level_lo;
    end else if (state_r == ladcl_pkg::LADCL_HIGH) begin
      current_nxt = finish ? ceil_r : level_hi;
    end else if (meas.valid && meas.half_cycle) begin
      if (over && current_r < ceil_r)
        current_nxt = 8'(current_r + `LADCL_ONE_BYTE);
      else if (under && current_r > floor_r)
        current_nxt = 8'(current_r - `LADCL_ONE_BYTE);
    end
    if (state_r == ladcl_pkg::LADCL_IDLE && enable_r) begin
      if (current_nxt > ceil_r)  current_nxt = ceil_r;
      if (current_nxt < floor_r) current_nxt = floor_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) current_r <= `LADCL_RST_CEIL;
    else          current_r <= current_nxt;
  end

  assign coil_current = current_r;
  assign adapt_active = enable_r;

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enable_r <= 1'b0;
      comp_r   <= 1'b0;
    end else if (wr_ctrl) begin
      enable_r <= bus_req.wdata[`LADCL_CTRL_EN_BIT];
      comp_r   <= bus_req.wdata[`LADCL_CTRL_COMP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      base_r      <= `LADCL_RST_BASE;
      inc_sel_r   <= `LADCL_RST_CODE;
      dwell_sel_r <= `LADCL_RST_CODE;
    end else if (wr_learn) begin
      base_r      <= bus_req.wdata[`LADCL_LRN_BASE_LSB +: 5];
      inc_sel_r   <= bus_req.wdata[`LADCL_LRN_INC_LSB +: 2];
      dwell_sel_r <= bus_req.wdata[`LADCL_LRN_DWELL_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      band_hi_r <= `LADCL_RST_BYTE;
      band_lo_r <= `LADCL_RST_BYTE;
    end else if (wr_band) begin
      band_hi_r <= bus_req.wdata[`LADCL_BAND_HI_LSB +: 8];
      band_lo_r <= bus_req.wdata[`LADCL_BAND_LO_LSB +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      floor_r <= `LADCL_RST_BYTE;
      ceil_r  <= `LADCL_RST_CEIL;
    end else if (wr_limit) begin
      floor_r <= bus_req.wdata[`LADCL_LIM_FLOOR_LSB +: 8];
      ceil_r  <= bus_req.wdata[`LADCL_LIM_CEIL_LSB +: 8];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // fields are placed by the same positions the write side decodes, so a
  // moved field cannot read back from a different place than it is written
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (bus_req.addr)
      `LADCL_OFS_CTRL: begin
        rdata_nxt[`LADCL_CTRL_EN_BIT]   = enable_r;
        rdata_nxt[`LADCL_CTRL_COMP_BIT] = comp_r;
        rdata_nxt[`LADCL_CTRL_GO_BIT]   = go_r;
      end
      `LADCL_OFS_LEARN: begin
        rdata_nxt[`LADCL_LRN_BASE_LSB +: 5]  = base_r;
        rdata_nxt[`LADCL_LRN_INC_LSB +: 2]   = inc_sel_r;
        rdata_nxt[`LADCL_LRN_DWELL_LSB +: 2] = dwell_sel_r;
      end
      `LADCL_OFS_STATUS: begin
        rdata_nxt[`LADCL_ST_DONE_BIT]  = done_r;
        rdata_nxt[`LADCL_ST_ABOVE_BIT] = above_r;
        rdata_nxt[`LADCL_ST_BELOW_BIT] = below_r;
      end
      `LADCL_OFS_LOSS_LO: rdata_nxt[10:0] = loss_lo_r;
      `LADCL_OFS_LOSS_HI: rdata_nxt[10:0] = loss_hi_r;
      `LADCL_OFS_BAND: begin
        rdata_nxt[`LADCL_BAND_LO_LSB +: 8] = band_lo_r;
        rdata_nxt[`LADCL_BAND_HI_LSB +: 8] = band_hi_r;
      end
      `LADCL_OFS_LIMIT: begin
        rdata_nxt[`LADCL_LIM_FLOOR_LSB +: 8] = floor_r;
        rdata_nxt[`LADCL_LIM_CEIL_LSB +: 8]  = ceil_r;
      end
      `LADCL_OFS_PRESENT: rdata_nxt[7:0] = current_r;
      default:            rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data stands for one cycle only and is zero otherwise, so a stale
  // word can never be mistaken for a fresh answer

  always_ff @(posedge clk) begin
    if (!reset_n)       bus_rdata <= 32'h0000_0000;
    else if (bus_req.rd) bus_rdata <= rdata_nxt;
    else                bus_rdata <= 32'h0000_0000;
  end

endmodule

// >>> verif/ladcl_monitor.sv
// checker: concurrent checks on the ports of ladcl_top.
// assumes meas.valid stays low while learning runs.
`timescale 1ns/1ps
`include "ladcl_params.svh"
module ladcl_monitor (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      reset_n,
  // watched ports
  input wire ladcl_pkg::ladcl_bus_req_t bus_req,
  input wire logic [31:0]               bus_rdata,
  input wire ladcl_pkg::ladcl_meas_t    meas,
  input wire logic [7:0]                coil_current,
  input wire logic                      adapt_active
);
  // ****************
  // shadow of fields
  // ****************
  logic [7:0]  ceil_r, flo_r, up_r, lo_r;
  logic [4:0]  base_r;
  logic [1:0]  inc_r;
  logic        comp_r, lrn_r;
  wire  [31:0] w   = bus_req.wdata;
  wire  [7:0]  lvl = {base_r, 3'h0};
  wire  [7:0]  inc = (inc_r == 2'h0) ? 8'h80 : 8'h08 << inc_r;
  // scaled bands are not modelled, so loop checks pause while compensating
  wire         hc  = adapt_active && !comp_r && meas.valid && meas.half_cycle;
  wire         inl = coil_current >= flo_r && coil_current <= ceil_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {ceil_r, flo_r, up_r, lo_r} <= 32'hFF00_0000;
      {base_r, inc_r, comp_r, lrn_r} <= 9'h000;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `LADCL_OFS_CTRL:  {lrn_r, comp_r} <= {w[2] & w[0], w[1]};
        `LADCL_OFS_LEARN: {inc_r, base_r} <= {w[9:8], w[4:0]};
        `LADCL_OFS_BAND:  {up_r, lo_r} <= w[15:0];
        `LADCL_OFS_LIMIT: {ceil_r, flo_r} <= w[15:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_go;
    bus_req.wr && bus_req.addr == `LADCL_OFS_CTRL && w[2] && w[0];
  endsequence
  sequence s_low;
    ##[2:4] coil_current == lvl;
  endsequence
  a_learn_low: assert property (s_go |-> s_low)
    else $error("learning did not start at the first level");
  a_second_level: assert property (lrn_r && $past(coil_current) == lvl
    && coil_current != lvl |-> coil_current == lvl + inc) else $error("bad second level");
  a_raise_step: assert property (hc && meas.load > up_r && inl && coil_current != ceil_r
    |=> coil_current == $past(coil_current) + 8'h01) else $error("no raise above band");
  a_lower_step: assert property (hc && meas.load < lo_r && inl && coil_current != flo_r
    |=> coil_current == $past(coil_current) - 8'h01) else $error("no drop below band");
  a_hold_ceiling: assert property (hc && meas.load > up_r && coil_current == ceil_r
    |=> coil_current == ceil_r) else $error("current passed the ceiling");
  a_hold_floor: assert property (hc && meas.load < lo_r && coil_current == flo_r
    |=> coil_current == flo_r) else $error("current passed the floor");
  a_band_hold: assert property (hc && meas.load <= up_r && meas.load >= lo_r && inl
    |=> $stable(coil_current)) else $error("current moved inside band");
  a_off_ceiling: assert property (!adapt_active && !$past(adapt_active)
    |-> coil_current == ceil_r || coil_current == $past(ceil_r)) else $error("idle not ceiling");
  a_rd_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind ladcl_top ladcl_monitor ladcl_monitor_inst (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .meas(meas), .coil_current(coil_current), .adapt_active(adapt_active));

// >>> verif/ladcl_coil_model.sv
// partner: coil regulator and metric engine as seen by the block.
// assumes a free-running half-cycle strobe; loss follows the coil current.
`timescale 1ns/1ps
module ladcl_coil_model #(
  parameter int PER = 8
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               reset_n,
  // block side
  input wire logic [7:0]         coil_current,
  output ladcl_pkg::ladcl_meas_t meas,
  // bench controls
  input wire logic [7:0]         load_lvl,
  input wire logic               valid_en
);
  logic [3:0] tick_r;
  // invalid samples toggle so a stale load never looks trustworthy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tick_r <= 4'h0;
      meas   <= '0;
    end else begin
      tick_r          <= (tick_r == 4'(PER - 1)) ? 4'h0 : tick_r + 4'h1;
      meas.half_cycle <= tick_r == 4'(PER - 1);
      meas.loss       <= {3'h0, coil_current} + 11'h010;
      meas.load       <= valid_en ? load_lvl : ~meas.load;
      meas.valid      <= valid_en;
    end
  end
endmodule

// >>> verif/testbench.sv
// bench: drives ladcl_top over its register port beside the coil model.
// assumes the monitor is bound in; half-cycle period is eight clocks.
`timescale 1ns/1ps
`include "ladcl_params.svh"
module testbench;
  logic                      clk;
  logic                      reset_n;
  ladcl_pkg::ladcl_bus_req_t bus_req;
  logic [31:0]               bus_rdata;
  ladcl_pkg::ladcl_meas_t    meas;
  logic [8:0]                supply_gain;
  logic [7:0]                coil_current;
  logic                      adapt_active;
  logic [7:0]                load_lvl;
  logic                      valid_en;
  logic [31:0]               rv;
  logic                      hc_prev;
  int                        errors;
  int                        check_count;
  int                        cyc;
  ladcl_top ladcl_top_inst (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .meas(meas), .supply_gain(supply_gain),
    .coil_current(coil_current), .adapt_active(adapt_active));
  ladcl_coil_model #(.PER(8)) ladcl_coil_model_inst (.clk(clk), .reset_n(reset_n),
    .coil_current(coil_current), .meas(meas), .load_lvl(load_lvl), .valid_en(valid_en));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask
  task automatic wait_coil(input logic [7:0] v);
    hc_prev = 1'b0;
    for (int i = 0; i < 3000 && coil_current !== v; i++) begin
      @(posedge clk);
      #1;
      // the coil lags the level by one edge; a pulse there still counts
      if (coil_current !== v) hc_prev = meas.half_cycle;
    end
  endtask
  task automatic count_at(input logic [7:0] v, output int n);
    n = 0;
    for (int i = 0; i < 3000 && coil_current === v; i++) begin
      if (meas.half_cycle === 1'b1) n++;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    for (int a = 0; a <= 32; a += 4) begin
      if (a != 28) begin
        rd(8'(a));
        chk("reset word", (a == 24) ? 32'h0000_FF00 : 32'h0, rv);
      end
    end
  endtask
  task automatic t_regs();
    wr(`LADCL_OFS_BAND, 32'hFFFF_2220);
    wr(`LADCL_OFS_LIMIT, 32'h0000_F0E0);
    wr(`LADCL_OFS_LOSS_LO, 32'hFFFF_FFFF);
    wr(`LADCL_OFS_STATUS, 32'hFFFF_FFFF);
    rd(`LADCL_OFS_BAND);
    chk("band", 32'h0000_2220, rv);
    rd(`LADCL_OFS_LIMIT);
    chk("limits", 32'h0000_F0E0, rv);
    rd(`LADCL_OFS_LOSS_LO);
    chk("loss preload", 32'h0000_07FF, rv);
    rd(`LADCL_OFS_STATUS);
    chk("status read only", 32'h0, rv);
  endtask
  task automatic t_learn(input logic [4:0] b, input logic [1:0] ic, input logic [1:0] dc);
    logic [7:0] lo;
    logic [7:0] hi;
    int         n;
    lo = {b, 3'h0};
    hi = lo + ((ic == 2'h0) ? 8'h80 : 8'h08 << ic);
    wr(`LADCL_OFS_CTRL, 32'h1);
    wr(`LADCL_OFS_LEARN, {14'h0, dc, 6'h0, ic, 3'h0, b});
    wr(`LADCL_OFS_CTRL, 32'h5);
    wait_coil(lo);
    count_at(lo, n);
    chk("first dwell", {26'h0, dc + 3'h1, 3'h0}, n + int'(hc_prev));
    chk("second level", {24'h0, hi}, {24'h0, coil_current});
    count_at(hi, n);
    chk("second dwell", {26'h0, dc + 3'h1, 3'h0}, n);
    chk("after learning", 32'h0000_00F0, {24'h0, coil_current});
    rd(`LADCL_OFS_CTRL);
    chk("go cleared", 32'h1, rv);
    rd(`LADCL_OFS_STATUS);
    chk("done", 32'h1, {31'h0, rv[0]});
    rd(`LADCL_OFS_LOSS_LO);
    chk("loss low", {21'h0, {3'h0, lo} + 11'h010}, rv);
    rd(`LADCL_OFS_LOSS_HI);
    chk("loss high", {21'h0, {3'h0, hi} + 11'h010}, rv);
  endtask
  task automatic t_loop(input logic [7:0] load, input logic [7:0] lvl, input logic [1:0] fl);
    load_lvl <= load;
    valid_en <= 1'b1;
    wait_coil(lvl);
    repeat (10) @(posedge clk);
    chk("loop level", {24'h0, lvl}, {24'h0, coil_current});
    rd(`LADCL_OFS_PRESENT);
    chk("present level", {24'h0, lvl}, rv);
    rd(`LADCL_OFS_STATUS);
    chk("band flags", {30'h0, fl}, {30'h0, rv[2:1]});
  endtask
  task automatic t_supply();
    supply_gain <= 9'h080;
    load_lvl <= 8'h18;
    wr(`LADCL_OFS_CTRL, 32'h3);
    repeat (10) @(posedge clk);
    rd(`LADCL_OFS_STATUS);
    chk("scaled band", 32'h1, {30'h0, rv[2:1]});
    supply_gain <= 9'h100;
    repeat (10) @(posedge clk);
    rd(`LADCL_OFS_STATUS);
    chk("unity band", 32'h2, {30'h0, rv[2:1]});
  endtask
  task automatic t_disable();
    valid_en <= 1'b0;
    wr(`LADCL_OFS_CTRL, 32'h0);
    wr(`LADCL_OFS_CTRL, 32'h4);
    repeat (40) @(posedge clk);
    chk("disabled", 32'h0000_00F0, {23'h0, adapt_active, coil_current});
    rd(`LADCL_OFS_CTRL);
    chk("go refused", 32'h0, rv);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    supply_gain = 9'h100;
    load_lvl = 8'h00;
    valid_en = 1'b0;
    errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_learn(5'h0A, 2'h0, 2'h0);
    for (int k = 1; k < 4; k++) t_learn(5'h12, 2'(k), 2'(k));
    t_loop(8'h10, 8'hE0, 2'h2);
    t_loop(8'h30, 8'hF0, 2'h1);
    t_loop(8'h21, 8'hF0, 2'h0);
    t_supply();
    t_disable();
    report_and_stop();
  end
endmodule
